/* dv/sdc_ctrl_props.sv */
`default_nettype none
// Watches the sequencer's pins for command spacing slips
module sdc_ctrl_props
   import sdc_pkg::*;
(
   // Clock, reset and user port
   input wire logic        SYS_CLK_I,
   input wire logic        RESET_N_I,
   input wire logic        REQ_VALID_I,
   input wire sdc_req_t    REQ_KIND_I,
   input wire logic [1:0]  REQ_BANK_I,
   input wire logic [11:0] REQ_ADDR_I,
   input wire logic        REQ_READY_O,
   input wire logic        INIT_DONE_O,
   // Memory pins
   input wire logic        MEM_CKE_O,
   input wire logic        MEM_CS_N_O,
   input wire logic        MEM_RAS_N_O,
   input wire logic        MEM_CAS_N_O,
   input wire logic        MEM_WE_N_O,
   input wire logic [1:0]  MEM_BA_O,
   input wire logic [11:0] MEM_ADDR_O,
   input wire logic [3:0]  MEM_DQM_O
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic [3:0] cmd = {MEM_CS_N_O, MEM_RAS_N_O, MEM_CAS_N_O, MEM_WE_N_O};  // Pin command
   wire logic       act = (cmd == SDC_CMD_ACT);                 // Row open
   wire logic       pre = (cmd == SDC_CMD_PRE);                 // Row close
   wire logic       col = (cmd == SDC_CMD_RD) || (cmd == SDC_CMD_WR);  // Column access
   logic [7:0]      a_age [4];                                  // Cycles since activate
   logic [7:0]      p_age [4];                                  // Cycles since precharge
   // Saturating ages, so an old event never wraps round to look recent
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         a_age <= '{default: 8'hff};
         p_age <= '{default: 8'hff};
      end else begin
         for (int i = 0; i < 4; i++) begin
            a_age[i] <= (act && MEM_BA_O == i) ? 8'h01 : a_age[i] + {7'h0, a_age[i] != 8'hff};
            p_age[i] <= (pre && (MEM_ADDR_O[10] || MEM_BA_O == i)) ? 8'h01
                        : p_age[i] + {7'h0, p_age[i] != 8'hff};
         end
      end
   end
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   AST_RC: assert property (act |-> a_age[MEM_BA_O] >= RC_CYC)
      else $error("activate too soon after activate on one bank");
   AST_RRD: assert property (act |=> !act)
      else $error("activates on two banks too close");
   AST_RCD: assert property (col |-> a_age[MEM_BA_O] >= RCD_CYC)
      else $error("column command too soon after activate");
   AST_RP: assert property (act |-> p_age[MEM_BA_O] >= RP_CYC)
      else $error("activate too soon after precharge");
   AST_REF: assert property (cmd == SDC_CMD_REF |-> p_age[0] >= RP_CYC && p_age[1] >= RP_CYC
      && p_age[2] >= RP_CYC && p_age[3] >= RP_CYC) else $error("refresh too soon after precharge");
   AST_RAS: assert property (pre && !MEM_ADDR_O[10] |-> a_age[MEM_BA_O] >= RAS_CYC)
      else $error("row closed too early");
   AST_RAS_ALL: assert property (pre && MEM_ADDR_O[10] |-> a_age[0] >= RAS_CYC
      && a_age[1] >= RAS_CYC && a_age[2] >= RAS_CYC && a_age[3] >= RAS_CYC)
      else $error("row closed too early by all-bank precharge");
   AST_MRS: assert property (cmd == SDC_CMD_MRS |=> cmd == SDC_CMD_NOP)
      else $error("command right after mode set");
   AST_CKE: assert property (MEM_CKE_O)
      else $error("clock gate low");
   AST_DQM: assert property (!INIT_DONE_O |-> MEM_DQM_O == 4'hf)
      else $error("mask low before init end");
   AST_READY: assert property (REQ_READY_O |-> INIT_DONE_O)
      else $error("request taken during init");
   AST_ANSWER: assert property (REQ_VALID_I && REQ_READY_O && REQ_KIND_I == SDC_REQ_RD
      |=> cmd == SDC_CMD_RD && MEM_BA_O == $past(REQ_BANK_I)) else $error("read not issued");
endmodule // sdc_ctrl_props
bind sdc_ctrl sdc_ctrl_props i_sdc_ctrl_props (.SYS_CLK_I, .RESET_N_I, .REQ_VALID_I,
   .REQ_KIND_I, .REQ_BANK_I, .REQ_ADDR_I, .REQ_READY_O, .INIT_DONE_O, .MEM_CKE_O, .MEM_CS_N_O,
   .MEM_RAS_N_O, .MEM_CAS_N_O, .MEM_WE_N_O, .MEM_BA_O, .MEM_ADDR_O, .MEM_DQM_O);
`default_nettype wire

/* dv/sdc_mem_model.sv */
`default_nettype none
// Memory device: decodes pin commands and counts spacing or order faults
module sdc_mem_model
   import sdc_pkg::*;
#(
   parameter int PAUSE   = 10,  // Least power-up pause in cycles
   parameter int REF_MAX = 260  // Longest gap between refreshes
) (
   // Clock, power-on and command pins
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        cke_i,
   input  wire logic [3:0]  cmd_i,
   input  wire logic [1:0]  ba_i,
   input  wire logic [11:0] addr_i,
   input  wire logic [3:0]  dqm_i,
   // Findings
   output int               err_o = 0,
   output int               refs_o,
   output logic [11:0]      mode_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int         cyc, t_any, t_mrs, t_ref, phase;  // Phase: 0 pause, 1 closed, 2 mode, 4 ready
   int         t_act [4];                        // Cycle of last activate
   int         t_pre [4];                        // Cycle of last precharge
   logic [3:0] open_b;                           // Banks with a row open
   // Every rising edge registers one command
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         {cyc, phase, refs_o, open_b, mode_o} = '0;
         {t_any, t_mrs, t_ref} = {3{-99}};
         t_act = '{default: -99};
         t_pre = '{default: -99};
      end else begin
         cyc++;
         if (!cke_i || (phase == 0 && dqm_i !== 4'hf)) err_o++;
         if (cmd_i != SDC_CMD_NOP && cyc - t_mrs < T_MRS_CYC) err_o++;
         for (int b = 0; b < 4; b++)
            if (open_b[b] && cyc - t_act[b] > RAS_MAX_CYC) err_o++;
         if (phase == 4 && cyc - t_ref > REF_MAX) err_o++;
         case (cmd_i)
            SDC_CMD_NOP: ;
            SDC_CMD_PRE: begin
               if (phase == 0 && (cyc < PAUSE || !addr_i[10])) err_o++;
               for (int b = 0; b < 4; b++)
                  if (addr_i[10] || ba_i == b) begin
                     if (open_b[b] && cyc - t_act[b] < RAS_CYC) err_o++;
                     open_b[b] = 1'b0;
                     t_pre[b] = cyc;
                  end
               if (phase == 0) phase = 1;
            end
            SDC_CMD_MRS: begin
               if (phase != 1) err_o++;
               phase = 2;
               t_mrs = cyc;
               mode_o = addr_i;
            end
            SDC_CMD_REF: begin  // Row address comes from inside
               if (phase < 2 || open_b != 4'h0 || cyc - t_ref < RC_CYC) err_o++;
               for (int b = 0; b < 4; b++)
                  if (cyc - t_pre[b] < RP_CYC) err_o++;
               if (phase == 2 || phase == 3) phase++;
               t_ref = cyc;
               refs_o++;
            end
            SDC_CMD_ACT: begin
               if (phase != 4 || open_b[ba_i] || cyc - t_act[ba_i] < RC_CYC) err_o++;
               if (cyc - t_any < RRD_CYC || cyc - t_pre[ba_i] < RP_CYC) err_o++;
               open_b[ba_i] = 1'b1;
               t_act[ba_i] = cyc;
               t_any = cyc;
            end
            SDC_CMD_RD, SDC_CMD_WR:  // A column every cycle is fine
               if (phase != 4 || !open_b[ba_i] || cyc - t_act[ba_i] < RCD_CYC) err_o++;
            default: err_o++;
         endcase
      end
   end
endmodule // sdc_mem_model
`default_nettype wire

/* dv/test_sdc_ctrl.sv */
`default_nettype none
// Self-checking bench for the command sequencer
module test_sdc_ctrl
   import sdc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PAUSE = 10;   // Shortened pause
   localparam int REFI  = 200;  // Shortened refresh interval
   logic        clk = 1'b0, rst_n = 1'b0, valid = 1'b0;  // Bench drives
   sdc_req_t    kind = SDC_REQ_ACT, k;
   logic [1:0]  bank = 2'h0, ba, b;
   logic [11:0] addr = 12'h000, ma, mode, a;
   logic        ready, done, cke, cs_n, ras_n, cas_n, we_n;  // Design outputs
   logic [3:0]  dqm, open_b = 4'h0;                          // Open banks seen on pins
   logic [31:0] seed = 32'h8532;
   int          n_fail = 0, n_tests = 0, cyc = 0, err, refs, w, t0;
   wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
   always #5 clk = ~clk;
   sdc_ctrl #(.PAUSE_CYCLES(PAUSE), .REFRESH_CYCLES(REFI)) i_sdc_ctrl (.SYS_CLK_I(clk),
      .RESET_N_I(rst_n), .REQ_VALID_I(valid), .REQ_KIND_I(kind), .REQ_BANK_I(bank),
      .REQ_ADDR_I(addr), .REQ_READY_O(ready), .INIT_DONE_O(done), .MEM_CKE_O(cke),
      .MEM_CS_N_O(cs_n), .MEM_RAS_N_O(ras_n), .MEM_CAS_N_O(cas_n), .MEM_WE_N_O(we_n),
      .MEM_BA_O(ba), .MEM_ADDR_O(ma), .MEM_DQM_O(dqm));
   sdc_mem_model #(.PAUSE(PAUSE)) i_sdc_mem_model (.clk_i(clk), .rst_n_i(rst_n), .cke_i(cke),
      .cmd_i(cmd), .ba_i(ba), .addr_i(ma), .dqm_i(dqm), .err_o(err), .refs_o(refs), .mode_o(mode));
   // Follow open rows from the pins, reset closes them too
   always @(posedge clk) begin
      #1;
      cyc++;
      if (cmd == SDC_CMD_ACT) open_b[ba] = 1'b1;
      if (cmd == SDC_CMD_PRE) open_b = ma[10] ? 4'h0 : open_b & ~(4'h1 << ba);
      if (!rst_n) open_b = 4'h0;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return s[0] ? (s >> 1) ^ 32'h80200003 : s >> 1;
   endfunction
   // Pin code {cs, ras, cas, we} for each request kind
   function automatic logic [3:0] exp_cmd(input sdc_req_t r);
      return (r == SDC_REQ_ACT) ? 4'h3 : (r == SDC_REQ_RD) ? 4'h5 : (r == SDC_REQ_WR) ? 4'h4 : 4'h2;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic chk_ge(input int got, input int least, input string what);
      chk(got >= least, 1'b1, what);
   endtask
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic idle;
      valid = 1'b0;
      @(posedge clk) #2;
   endtask
   // Hold a request until taken, withdraw it if its row got closed
   task automatic req(input sdc_req_t r, input logic [1:0] rb, input logic [11:0] ra);
      {valid, kind, bank, addr} = {1'b1, r, rb, ra};
      // Ready is looked at mid-cycle, once it has settled on the new request
      w = 0;
      @(negedge clk);
      while (ready !== 1'b1) begin
         if (w > 60 || (r != SDC_REQ_ACT && !open_b[rb])) begin
            if (w > 60) chk(0, 1, "request never taken");
            w = -1;
            @(posedge clk) #2;
            idle();
            return;
         end
         w++;
         @(negedge clk);
      end
      @(posedge clk) #2;
      chk(cmd, exp_cmd(r), "command code");
      chk(ba, rb, "bank");
      if (r != SDC_REQ_PRE) chk(ma, ra, "address");
   endtask
   task automatic wait_init;
      for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge clk) #2;
      chk(done, 1, "init done");
      chk_ge(refs, INIT_REFS, "init refreshes");
      chk(mode, 12'h022, "mode image");
      chk(dqm, 4'h0, "mask after init");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      #2 rst_n = 1'b1;
      wait_init();
      req(SDC_REQ_ACT, 2'h0, 12'h5a5);
      t0 = cyc;
      req(SDC_REQ_ACT, 2'h1, 12'h0f0);
      chk_ge(cyc - t0, RRD_CYC, "bank to bank");
      req(SDC_REQ_RD, 2'h0, 12'h003);
      chk_ge(cyc - t0, RCD_CYC, "activate to read");
      req(SDC_REQ_RD, 2'h0, 12'h004);
      chk(w, 0, "second read stalled");
      req(SDC_REQ_WR, 2'h1, 12'h1ff);
      chk(w, 0, "write stalled");
      req(SDC_REQ_PRE, 2'h0, 12'h000);
      chk_ge(cyc - t0, RAS_CYC, "row open time");
      req(SDC_REQ_ACT, 2'h0, 12'h123);
      chk_ge(cyc - t0, RC_CYC, "row cycle");
      repeat (300) begin
         seed = lfsr(seed);
         b = seed[1:0];
         k = open_b[b] ? sdc_req_t'((seed[3:2] == 2'h0) ? 2'h1 : seed[3:2]) : SDC_REQ_ACT;
         a = seed[15:4];
         if (k == SDC_REQ_RD || k == SDC_REQ_WR) a[10] = 1'b0;
         req(k, b, a);
         if (seed[20]) idle();
      end
      idle();
      rst_n = 1'b0;
      #1;
      chk({cmd, dqm, cke, done, ready}, 11'h3fc, "pins in reset");
      repeat (2) @(posedge clk);
      #2 rst_n = 1'b1;
      wait_init();
      chk(err, 0, "device findings");
      wrap_up();
   end
   initial begin
      #400000;
      chk(0, 1, "run timed out");
      wrap_up();
   end
endmodule // test_sdc_ctrl
`default_nettype wire

/* rtl/sdc_bank_if.sv */
`default_nettype none
// Per-bank timing grants between the sequencer and the timer bank
interface sdc_bank_if;
   import sdc_pkg::*;
   logic [3:0] act_ev;    // Activate issued, one bit per bank; refresh sets all four
   logic [3:0] pre_ev;    // Precharge issued
   logic [3:0] col_ev;    // Column command issued
   logic [3:0] act_ok;    // Activate allowed
   logic [3:0] col_ok;    // Column command allowed
   logic [3:0] pre_ok;    // Precharge allowed
   logic [3:0] ras_late;  // Row open near its longest time
   modport seq (output act_ev, pre_ev, col_ev, input act_ok, col_ok, pre_ok, ras_late);
   modport tmr (input act_ev, pre_ev, col_ev, output act_ok, col_ok, pre_ok, ras_late);
endinterface : sdc_bank_if
`default_nettype wire

/* rtl/sdc_bank_timer.sv */
`default_nettype none
// Per-bank interval counters
module sdc_bank_timer
   import sdc_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   sdc_bank_if.tmr  bus
);
   localparam int W = 16;
   logic [W-1:0] rc_cnt  [4];   // Since last activate, same bank
   logic [W-1:0] rp_cnt  [4];   // Since last precharge
   logic [W-1:0] rcd_cnt [4];   // Activate to column
   logic [W-1:0] ras_cnt [4];   // Open row age
   logic [3:0]   open;          // Row open flags

   initial assert (RAS_MAX_CYC < (1 << W));

   // Counters saturate at their target values
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int b = 0; b < 4; b++) begin
            rc_cnt[b]  <= W'(RC_CYC);
            rp_cnt[b]  <= W'(RP_CYC);
            rcd_cnt[b] <= '0;
            ras_cnt[b] <= '0;
         end
         open <= 4'h0;
      end else begin
         for (int b = 0; b < 4; b++) begin
            if (bus.act_ev[b]) begin
               rc_cnt[b]  <= W'(1);
               rcd_cnt[b] <= W'(1);
               ras_cnt[b] <= W'(1);
               open[b]    <= 1'b1;
            end else begin
               if (rc_cnt[b] < W'(RC_CYC)) rc_cnt[b] <= rc_cnt[b] + W'(1);
               if (rcd_cnt[b] < W'(RCD_CYC)) rcd_cnt[b] <= rcd_cnt[b] + W'(1);
               if (open[b] && ras_cnt[b] < W'(RAS_MAX_CYC)) ras_cnt[b] <= ras_cnt[b] + W'(1);
            end
            if (bus.pre_ev[b]) begin
               rp_cnt[b] <= W'(1);
               open[b]   <= 1'b0;
            end else if (rp_cnt[b] < W'(RP_CYC)) begin
               rp_cnt[b] <= rp_cnt[b] + W'(1);
            end
         end
      end
   end

   // Grants per bank
   always_comb begin
      for (int b = 0; b < 4; b++) begin
         bus.act_ok[b]   = !open[b] && rc_cnt[b] >= W'(RC_CYC)
                           && rp_cnt[b] >= W'(RP_CYC);
         bus.col_ok[b]   = open[b] && rcd_cnt[b] >= W'(RCD_CYC);
         bus.pre_ok[b]   = !open[b] || ras_cnt[b] >= W'(RAS_CYC);
         bus.ras_late[b] = open[b] && ras_cnt[b] >= W'(RAS_MAX_CYC - 16);
      end
   end
endmodule : sdc_bank_timer
`default_nettype wire

/* rtl/sdc_ctrl.sv */
`default_nettype none
// Operation
// - Same-bank activates spaced by row cycle
// - Different-bank activates spaced by tRRD
// - Activate to column wait tRCD
// - Precharge to activate/refresh wait tRP
// - Row open between min and max
// - Column commands may follow every cycle
// - Two cycles after mode register set
// - Initialization steps strictly in order
// - Hold NOP, clock gate, mask high
// - Wait 200 us before init
// - Keep byte mask high during pause
// - Precharge all before mode set
// - Program mode register during init
// - At least two refreshes end init
// - Refresh is RAS CAS low, WE high
// - 4096 refreshes every 64 ms
// - NOP fills idle and wait cycles
module sdc_ctrl
   import sdc_pkg::*;
#(
   parameter int PAUSE_CYCLES  = PAUSE_CYC,     // Power-up pause
   parameter int REFRESH_CYCLES = REF_INT_CYC,  // Refresh interval
   parameter logic [11:0] MODE_VALUE = 12'h022  // Mode register image
) (
   // Clock and reset
   input  wire logic        SYS_CLK_I,
   input  wire logic        RESET_N_I,
   // User request port
   input  wire logic        REQ_VALID_I,
   input  wire sdc_req_t    REQ_KIND_I,
   input  wire logic [1:0]  REQ_BANK_I,
   input  wire logic [11:0] REQ_ADDR_I,
   output logic             REQ_READY_O,
   output logic             INIT_DONE_O,
   // Memory command pins
   output logic             MEM_CKE_O,
   output logic             MEM_CS_N_O,
   output logic             MEM_RAS_N_O,
   output logic             MEM_CAS_N_O,
   output logic             MEM_WE_N_O,
   output logic [1:0]       MEM_BA_O,
   output logic [11:0]      MEM_ADDR_O,
   output logic [3:0]       MEM_DQM_O
);
   initial assert (PAUSE_CYCLES >= 1 && PAUSE_CYCLES < (1 << 24));
   initial assert (REFRESH_CYCLES > 64 && REFRESH_CYCLES < (1 << 24));

   typedef enum logic [2:0] {
      ST_PAUSE = 3'h0,
      ST_PALL  = 3'h1,
      ST_MRS   = 3'h2,
      ST_IREF  = 3'h3,
      ST_RUN   = 3'h4,
      ST_RPALL = 3'h5,
      ST_RREF  = 3'h6
   } sdc_state_t;

   sdc_state_t  state;        // Sequencer state
   logic [23:0] wait_cnt;     // Cycles until next command may issue
   logic [1:0]  ref_done;     // Initial refreshes issued
   logic [23:0] ref_cnt;      // Refresh interval counter
   logic        ref_pend;     // Refresh owed
   logic [3:0]  rrd_cnt;      // Since last activate, any bank
   logic [3:0]  open_mask;    // Banks opened by the refresh of the last cycle
   sdc_cmd_t    next_cmd;     // Command chosen this cycle
   logic [1:0]  next_ba;
   logic [11:0] next_addr;
   logic        take;         // User request accepted
   logic [3:0]  bank_hot;

   sdc_bank_if  bif ();

   // Per-bank interval counters
   sdc_bank_timer u_tmr (
      .sys_clk_i (SYS_CLK_I),
      .reset_n_i (RESET_N_I),
      .bus       (bif)
   );

   assign bank_hot = 4'h1 << REQ_BANK_I;

   // Request grant: only in run state, no wait, no refresh pending
   always_comb begin
      take = 1'b0;
      if (state == ST_RUN && wait_cnt == '0 && !ref_pend && REQ_VALID_I) begin
         unique case (REQ_KIND_I)
            SDC_REQ_ACT: take = |(bif.act_ok & bank_hot)
                                && rrd_cnt >= 4'(RRD_CYC);
            SDC_REQ_RD,
            SDC_REQ_WR:  take = |(bif.col_ok & bank_hot);
            SDC_REQ_PRE: take = REQ_ADDR_I[10] ? &bif.pre_ok        // All-bank form
                                : |(bif.pre_ok & bank_hot);
         endcase
      end
   end
   assign REQ_READY_O = take;

   // Command selection
   always_comb begin
      next_cmd  = SDC_CMD_NOP;
      next_ba   = 2'h0;
      next_addr = 12'h000;
      if (wait_cnt == '0) begin
         unique case (state)
            ST_PAUSE: next_cmd = SDC_CMD_NOP;
            ST_PALL, ST_RPALL: begin
               if (&bif.pre_ok) begin
                  next_cmd  = SDC_CMD_PRE;
                  next_addr = 12'h400;                              // All-bank precharge
               end
            end
            ST_MRS: begin
               next_cmd  = SDC_CMD_MRS;
               next_addr = MODE_VALUE;
            end
            ST_IREF, ST_RREF: begin
               if (&bif.act_ok) next_cmd = SDC_CMD_REF;
            end
            ST_RUN: begin
               if (take) begin
                  next_ba   = REQ_BANK_I;
                  next_addr = REQ_ADDR_I;
                  unique case (REQ_KIND_I)
                     SDC_REQ_ACT: next_cmd = SDC_CMD_ACT;
                     SDC_REQ_RD:  next_cmd = SDC_CMD_RD;
                     SDC_REQ_WR:  next_cmd = SDC_CMD_WR;
                     SDC_REQ_PRE: next_cmd = SDC_CMD_PRE;
                  endcase
               end
            end
            default: next_cmd = SDC_CMD_NOP;
         endcase
      end
   end

   // Bank events to the timers
   always_comb begin
      bif.act_ev = 4'h0;
      bif.col_ev = 4'h0;
      bif.pre_ev = open_mask;                                       // Close refresh's fake opening
      if (next_cmd == SDC_CMD_ACT) bif.act_ev = 4'h1 << next_ba;
      if (next_cmd == SDC_CMD_RD || next_cmd == SDC_CMD_WR) bif.col_ev = 4'h1 << next_ba;
      if (next_cmd == SDC_CMD_PRE)
         bif.pre_ev = next_addr[10] ? 4'hf : (4'h1 << next_ba);
      // Refresh occupies every bank for a row cycle
      if (next_cmd == SDC_CMD_REF) bif.act_ev = 4'hf;
   end

   // Refresh leaves rows closed: precharge the fake opening next cycle
   // Tracks rows opened only by refresh so they need no precharge command on the pins
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) open_mask <= 4'h0;
      else open_mask <= (next_cmd == SDC_CMD_REF) ? 4'hf : 4'h0;
   end

   // Sequencer state and wait counter
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         state    <= ST_PAUSE;
         wait_cnt <= 24'(PAUSE_CYCLES);
         ref_done <= 2'h0;
      end else if (wait_cnt != '0) begin
         wait_cnt <= wait_cnt - 24'h000001;
      end else begin
         unique case (state)
            ST_PAUSE: state <= ST_PALL;
            ST_PALL:  if (next_cmd == SDC_CMD_PRE) state <= ST_MRS;
            ST_MRS: begin
               state    <= ST_IREF;
               wait_cnt <= 24'(T_MRS_CYC - 1);
            end
            ST_IREF: if (next_cmd == SDC_CMD_REF) begin
               if (ref_done == 2'(INIT_REFS - 1)) state <= ST_RUN;
               ref_done <= ref_done + 2'h1;
            end
            ST_RUN:   if (ref_pend && !take) state <= ST_RPALL;
            ST_RPALL: if (next_cmd == SDC_CMD_PRE) state <= ST_RREF;
            ST_RREF:  if (next_cmd == SDC_CMD_REF) state <= ST_RUN;
            default:  state <= ST_PAUSE;
         endcase
      end
   end

   // Refresh interval timer, started once initialization ends
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         ref_cnt  <= 24'h000000;
         ref_pend <= 1'b0;
      end else if (state == ST_RUN || state == ST_RPALL || state == ST_RREF) begin
         if (ref_cnt >= 24'(REFRESH_CYCLES - 1) || |bif.ras_late) begin
            ref_cnt  <= 24'h000000;
            ref_pend <= 1'b1;
         end else begin
            ref_cnt <= ref_cnt + 24'h000001;
            if (next_cmd == SDC_CMD_REF) ref_pend <= 1'b0;
         end
      end
   end

   // Spacing between activates to any bank
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) rrd_cnt <= 4'(RRD_CYC);
      else if (next_cmd == SDC_CMD_ACT) rrd_cnt <= 4'h1;
      else if (rrd_cnt < 4'(RRD_CYC)) rrd_cnt <= rrd_cnt + 4'h1;
   end

   // Registered pin drivers
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         MEM_CKE_O   <= 1'b1;
         MEM_CS_N_O  <= 1'b0;
         MEM_RAS_N_O <= 1'b1;
         MEM_CAS_N_O <= 1'b1;
         MEM_WE_N_O  <= 1'b1;
         MEM_BA_O    <= 2'h0;
         MEM_ADDR_O  <= 12'h000;
         MEM_DQM_O   <= 4'hf;
         INIT_DONE_O <= 1'b0;
      end else begin
         {MEM_CS_N_O, MEM_RAS_N_O, MEM_CAS_N_O, MEM_WE_N_O} <= next_cmd;
         MEM_CKE_O   <= 1'b1;
         MEM_BA_O    <= next_ba;
         MEM_ADDR_O  <= next_addr;
         MEM_DQM_O   <= (state == ST_PAUSE || state == ST_PALL
                         || state == ST_MRS || state == ST_IREF) ? 4'hf : 4'h0;
         INIT_DONE_O <= (state == ST_RUN || state == ST_RPALL || state == ST_RREF);
      end
   end
endmodule : sdc_ctrl
`default_nettype wire

/* rtl/sdc_pkg.sv */
`default_nettype none
package sdc_pkg;
   // Clock period of SYS_CLK_I in picoseconds
   localparam int CLK_PERIOD_PS = 10000;
   // Documented intervals, faster grade, in picoseconds
   localparam int T_RC_PS   = 60000;
   localparam int T_RRD_PS  = 12000;
   localparam int T_RCD_PS  = 15000;
   localparam int T_RP_PS   = 15000;
   localparam int T_RAS_PS  = 42000;
   // Longest open row, nanoseconds
   localparam int T_RAS_MAX_NS = 120000;
   // Mode register set spacing and column spacing in cycles
   localparam int T_MRS_CYC  = 2;
   localparam int T_CCD_CYC  = 1;
   // Power-up pause in microseconds
   localparam int T_PAUSE_US = 200;
   // Refresh: operations per period and period in milliseconds
   localparam int REF_COUNT  = 4096;
   localparam int REF_PERIOD_MS = 64;
   // Minimum number of initial auto-refresh cycles
   localparam int INIT_REFS  = 2;

   // Least time rounds up, never below one cycle
   function automatic int cyc_up(input int ps);
      int c;
      c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int RC_CYC   = cyc_up(T_RC_PS);
   localparam int RRD_CYC  = cyc_up(T_RRD_PS);
   localparam int RCD_CYC  = cyc_up(T_RCD_PS);
   localparam int RP_CYC   = cyc_up(T_RP_PS);
   localparam int RAS_CYC  = cyc_up(T_RAS_PS);
   // Longest time rounds down
   localparam int RAS_MAX_CYC = (T_RAS_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int PAUSE_CYC   = cyc_up(T_PAUSE_US * 1000000);
   localparam int REF_INT_CYC = (REF_PERIOD_MS * 1000000 / REF_COUNT) * 1000 / CLK_PERIOD_PS;

   // Command codes {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      SDC_CMD_NOP  = 4'h7,
      SDC_CMD_ACT  = 4'h3,
      SDC_CMD_RD   = 4'h5,
      SDC_CMD_WR   = 4'h4,
      SDC_CMD_PRE  = 4'h2,
      SDC_CMD_REF  = 4'h1,
      SDC_CMD_MRS  = 4'h0
   } sdc_cmd_t;

   // Request kinds on the user port
   typedef enum logic [1:0] {
      SDC_REQ_ACT = 2'h0,
      SDC_REQ_RD  = 2'h1,
      SDC_REQ_WR  = 2'h2,
      SDC_REQ_PRE = 2'h3
   } sdc_req_t;
endpackage : sdc_pkg
`default_nettype wire
